// ==== inc/ltt_pkg.sv ====
// Constants shared by the low rate tick timer
package ltt_pkg;
  localparam int CNT_W = 8;
  localparam int IRQ_N = 4;
  localparam int PRESC_W = 17;
  // System clock period and the 256 Hz tick period, in ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 3906250;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Counter bit of each interrupt tap
  localparam int TAP32_BIT = 2;
  localparam int TAP8_BIT = 4;
  localparam int TAP2_BIT = 6;
  localparam int TAP1_BIT = 7;
  // Position of each tap in the flag and mask words
  localparam int IDX_TAP32 = 3;
  localparam int IDX_TAP8 = 2;
  localparam int IDX_TAP2 = 1;
  localparam int IDX_TAP1 = 0;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [IRQ_N-1:0] IRQ_NONE = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 17'h00000;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 17'h00001;
endpackage

// ==== design/ltt_tick_timer.sv ====
// Low rate tick timer: 8-bit counter on a 256 Hz tick with tap interrupts
// Functional notes
// - Eight-bit up-counter advanced by 256 Hz tick, all bits readable.
// - No counting tick reaches the counter while sleep mode is asserted.
// - Clear write or system reset forces the counter to zero.
// - Run bit one starts counting; zero gates the tick and halts.
// - Stop and start keep the counter value; counting resumes from it.
// - Run and clear written together: clear first, then count from zero.
// - While counting, falling edges of 32, 8, 2, 1 Hz taps from a count step raise causes.
// - Interrupt request forwarded only when that cause is enabled.
// - Run bit changes take effect at next 256 Hz falling edge.
// - After writing run zero, counter increments once more before halt.
// - Run bit reads one after stop request until counter really halts.
// - All four causes share one interrupt output; flags identify cause.
// - Real-time clock start restarts the 256 Hz prescaler phase.
// - Clear while running continues from zero; while stopped holds zero.
// - Each tap falling edge from a count step sets its flag; request needs enable one.
// - Flags cleared by writing one; software clears before enabling.
`timescale 1ns/100ps
module ltt_tick_timer #(
  parameter int TICK_CYCLES = ltt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // System state
  input wire logic sleep_mode,
  input wire logic rtc_start,
  // Timer control write
  input wire logic ctl_wr,
  input wire logic ctl_run_wdata,
  input wire logic ctl_clear_wdata,
  output logic run_control_bit,
  // Counter value
  output logic [ltt_pkg::CNT_W-1:0] counter_value,
  // Interrupt enables
  input wire logic mask_wr,
  input wire logic [ltt_pkg::IRQ_N-1:0] mask_wdata,
  output logic [ltt_pkg::IRQ_N-1:0] tick_mask,
  // Interrupt flags, cleared by writing one
  input wire logic flag_wr,
  input wire logic [ltt_pkg::IRQ_N-1:0] flag_wdata,
  output logic [ltt_pkg::IRQ_N-1:0] tick_flags,
  // Shared request to the interrupt controller unit
  output logic irq
);
  localparam logic [ltt_pkg::PRESC_W-1:0] PRESC_LAST =
    ltt_pkg::PRESC_W'(TICK_CYCLES - 1);

  logic [ltt_pkg::PRESC_W-1:0] presc_q, presc_d;
  logic tick;
  logic [ltt_pkg::CNT_W-1:0] cnt_q, cnt_d, cnt_inc;
  logic run_req_q, run_req_d;
  logic run_q, run_d;
  logic [ltt_pkg::IRQ_N-1:0] mask_q, mask_d;
  logic [ltt_pkg::IRQ_N-1:0] flag_q, flag_d, cause;
  logic irq_q, irq_d;
  logic clear_wr;

  assign clear_wr = ctl_wr && ctl_clear_wdata;

  // Prescaler: one tick per 256 Hz falling edge, frozen in sleep
  always_comb
  begin
    presc_d = presc_q;
    tick = 1'b0;
    if (rtc_start)
    begin
      presc_d = ltt_pkg::PRESC_RESET;
    end
    else if (!sleep_mode)
    begin
      if (presc_q == PRESC_LAST)
      begin
        presc_d = ltt_pkg::PRESC_RESET;
        tick = 1'b1;
      end
      else
      begin
        presc_d = presc_q + ltt_pkg::PRESC_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      presc_q <= ltt_pkg::PRESC_RESET;
    else
      presc_q <= presc_d;
  end

  // Counter and run control
  assign cnt_inc = cnt_q + ltt_pkg::CNT_ONE;

  always_comb
  begin
    run_req_d = run_req_q;
    run_d = run_q;
    cnt_d = cnt_q;
    if (ctl_wr)
    begin
      run_req_d = ctl_run_wdata;
    end
    if (tick)
    begin
      if (run_q)
      begin
        cnt_d = cnt_inc;
      end
      run_d = run_req_q;
    end
    if (clear_wr)
    begin
      cnt_d = ltt_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      run_req_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= ltt_pkg::CNT_RESET;
    end
    else
    begin
      run_req_q <= run_req_d;
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end

  // Tap falling edges while counting
  always_comb
  begin
    cause = ltt_pkg::IRQ_NONE;
    if (tick && run_q && !clear_wr)
    begin
      cause[ltt_pkg::IDX_TAP32] =
        cnt_q[ltt_pkg::TAP32_BIT] && !cnt_inc[ltt_pkg::TAP32_BIT];
      cause[ltt_pkg::IDX_TAP8] =
        cnt_q[ltt_pkg::TAP8_BIT] && !cnt_inc[ltt_pkg::TAP8_BIT];
      cause[ltt_pkg::IDX_TAP2] =
        cnt_q[ltt_pkg::TAP2_BIT] && !cnt_inc[ltt_pkg::TAP2_BIT];
      cause[ltt_pkg::IDX_TAP1] =
        cnt_q[ltt_pkg::TAP1_BIT] && !cnt_inc[ltt_pkg::TAP1_BIT];
    end
  end

  // Flags and mask; a new cause wins over a clear in the same cycle
  always_comb
  begin
    mask_d = mask_wr ? mask_wdata : mask_q;
    flag_d = flag_q;
    if (flag_wr)
    begin
      flag_d = flag_q & ~flag_wdata;
    end
    flag_d = flag_d | cause;
    irq_d = |(flag_d & mask_d);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mask_q <= ltt_pkg::IRQ_NONE;
      flag_q <= ltt_pkg::IRQ_NONE;
      irq_q <= 1'b0;
    end
    else
    begin
      mask_q <= mask_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  assign run_control_bit = run_req_q || run_q;
  assign counter_value = cnt_q;
  assign tick_mask = mask_q;
  assign tick_flags = flag_q;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_stop_edge;
    tick && run_q && !run_req_q && !clear_wr;
  endsequence

  sequence s_run_step;
    tick && run_q && !clear_wr;
  endsequence

  a_clear_to_zero: assert property (
    clear_wr |=> counter_value == ltt_pkg::CNT_RESET)
    else $error("counter not zero after clear");

  a_count_step: assert property (
    s_run_step |=> counter_value == $past(cnt_q) + ltt_pkg::CNT_ONE)
    else $error("counter did not step on tick");

  a_stopped_hold: assert property (
    !run_q && !clear_wr |=> $stable(counter_value))
    else $error("counter moved while stopped");

  a_stop_extra_step: assert property (
    s_stop_edge |=> !run_q &&
      counter_value == $past(cnt_q) + ltt_pkg::CNT_ONE)
    else $error("stop did not take one more step");

  a_run_read_held: assert property (
    run_q |-> run_control_bit)
    else $error("run bit read low before halt");

  a_run_waits_tick: assert property (
    !tick && !run_q |=> !run_q)
    else $error("run started off a tick");

  a_sleep_frozen: assert property (
    sleep_mode && !clear_wr |=> $stable(counter_value))
    else $error("counter moved in sleep");

  a_rtc_restart: assert property (
    rtc_start |-> !tick ##1 !tick [*8])
    else $error("tick too soon after rtc start");

  a_flag1_cause: assert property (
    $rose(tick_flags[ltt_pkg::IDX_TAP1]) |->
      $past(tick && run_q && cnt_q[ltt_pkg::TAP1_BIT]))
    else $error("1 Hz flag without tap edge");

  a_irq_masked: assert property (
    tick_mask == ltt_pkg::IRQ_NONE |=>
      !irq || $past(mask_wr))
    else $error("irq with all causes disabled");

  a_irq_flagged: assert property (
    irq |-> (tick_flags & tick_mask) != ltt_pkg::IRQ_NONE)
    else $error("irq without enabled flag");
endmodule

// ==== bench/ltt_intc_model.sv ====
// Interrupt controller stand-in that counts request rising edges
`timescale 1ns/100ps
module ltt_intc_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Shared request from the timer
  input wire logic irq,
  output logic [7:0] irq_count
);
  logic irq_q;
  always_ff @(posedge clk_sys)
  begin
    irq_q <= rst_n & irq;
    irq_count <= !rst_n ? 8'h00 : irq_count + {7'h00, irq & !irq_q};
  end
endmodule

// ==== bench/tb_ltt_tick_timer.sv ====
// Testbench for the low rate tick timer
`timescale 1ns/100ps
module tb_ltt_tick_timer;
  logic clk_sys = 1'b0, rst_n = 1'b0, sleep_mode = 1'b0, rtc_start = 1'b0;
  logic ctl_wr = 1'b0, ctl_run_wdata = 1'b0, ctl_clear_wdata = 1'b0;
  logic mask_wr = 1'b0, flag_wr = 1'b0, run_control_bit, irq;
  logic [3:0] mask_wdata = 4'h0, flag_wdata = 4'h0, tick_mask, tick_flags;
  logic [7:0] counter_value, irq_count;
  int n_errors = 0, checked = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  ltt_tick_timer #(.TICK_CYCLES(16)) u_ltt_tick_timer (.clk_sys(clk_sys),
    .rst_n(rst_n), .sleep_mode(sleep_mode), .rtc_start(rtc_start),
    .ctl_wr(ctl_wr), .ctl_run_wdata(ctl_run_wdata),
    .ctl_clear_wdata(ctl_clear_wdata), .run_control_bit(run_control_bit),
    .counter_value(counter_value), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata), .tick_mask(tick_mask), .flag_wr(flag_wr),
    .flag_wdata(flag_wdata), .tick_flags(tick_flags), .irq(irq));
  ltt_intc_model u_ltt_intc_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .irq(irq), .irq_count(irq_count));
  task finish_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Counter, run bit, flags and request in one go
  task st(input logic [7:0] c, input logic r, input logic [3:0] f,
    input logic i);
    chk("counter", counter_value, c);
    chk("run", {7'h00, run_control_bit}, {7'h00, r});
    chk("flags", {4'h0, tick_flags}, {4'h0, f});
    chk("irq", {7'h00, irq}, {7'h00, i});
  endtask
  task w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr_ctl(input logic run, input logic clr, input logic rtc);
    @(posedge clk_sys);
    ctl_wr <= 1'b1;
    ctl_run_wdata <= run;
    ctl_clear_wdata <= clr;
    rtc_start <= rtc;
    @(posedge clk_sys);
    ctl_wr <= 1'b0;
    rtc_start <= 1'b0;
  endtask
  // Mask write when m is one, else flag clear write
  task wr_irq(input logic m, input logic [3:0] d);
    @(posedge clk_sys);
    mask_wr <= m;
    flag_wr <= !m;
    mask_wdata <= d;
    flag_wdata <= d;
    @(posedge clk_sys);
    mask_wr <= 1'b0;
    flag_wr <= 1'b0;
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 9000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    w(1);
    st(8'h00, 1'b0, 4'h0, 1'b0);
    wr_ctl(1'b1, 1'b1, 1'b1);
    w(24);
    st(8'h00, 1'b1, 4'h0, 1'b0);
    w(48);
    st(8'h03, 1'b1, 4'h0, 1'b0);
    wr_ctl(1'b0, 1'b0, 1'b0);
    w(1);
    st(8'h03, 1'b1, 4'h0, 1'b0);
    w(13);
    st(8'h04, 1'b0, 4'h0, 1'b0);
    w(32);
    st(8'h04, 1'b0, 4'h0, 1'b0);
    wr_ctl(1'b1, 1'b0, 1'b0);
    w(30);
    st(8'h05, 1'b1, 4'h0, 1'b0);
    wr_ctl(1'b1, 1'b1, 1'b0);
    w(2);
    st(8'h00, 1'b1, 4'h0, 1'b0);
    w(12);
    st(8'h01, 1'b1, 4'h0, 1'b0);
    // Stop and wait for the halt before sleeping
    wr_ctl(1'b0, 1'b0, 1'b0);
    w(8);
    st(8'h02, 1'b0, 4'h0, 1'b0);
    @(posedge clk_sys);
    sleep_mode <= 1'b1;
    w(72);
    st(8'h02, 1'b0, 4'h0, 1'b0);
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
    // Tick phase shows the prescaler held still in sleep
    wr_ctl(1'b1, 1'b0, 1'b0);
    w(23);
    st(8'h02, 1'b1, 4'h0, 1'b0);
    w(5);
    st(8'h03, 1'b1, 4'h0, 1'b0);
    // Stop with a real-time clock start moves the halting tick
    wr_ctl(1'b0, 1'b0, 1'b1);
    w(14);
    st(8'h03, 1'b1, 4'h0, 1'b0);
    w(2);
    st(8'h04, 1'b0, 4'h0, 1'b0);
    wr_ctl(1'b0, 1'b1, 1'b0);
    w(40);
    st(8'h00, 1'b0, 4'h0, 1'b0);
    // Flags cleared, enables set, then clear and start
    wr_irq(1'b0, 4'hF);
    wr_irq(1'b1, 4'h7);
    wr_ctl(1'b1, 1'b1, 1'b1);
    w(144);
    st(8'h08, 1'b1, 4'h8, 1'b0);
    chk("mask", {4'h0, tick_mask}, 8'h07);
    wr_irq(1'b0, 4'h8);
    wr_irq(1'b1, 4'hF);
    w(1);
    st(8'h08, 1'b1, 4'h0, 1'b0);
    chk("mask", {4'h0, tick_mask}, 8'h0F);
    w(123);
    st(8'h10, 1'b1, 4'h8, 1'b1);
    wr_irq(1'b0, 4'h8);
    w(2);
    st(8'h10, 1'b1, 4'h0, 1'b0);
    chk("irq edges", irq_count, 8'h01);
    w(252);
    st(8'h20, 1'b1, 4'hC, 1'b1);
    w(3584);
    st(8'h00, 1'b1, 4'hF, 1'b1);
    chk("irq edges", irq_count, 8'h02);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    w(1);
    st(8'h00, 1'b0, 4'h0, 1'b0);
    chk("mask", {4'h0, tick_mask}, 8'h00);
    finish_test();
  end
endmodule
